// ===== bench/rail_partner.sv
// Partner model: mains crossing source and raw rail response
`timescale 1ns/1ps
module rail_partner #(
   parameter int HALF = 30
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic lineOn,
   input wire logic sag,
   input wire logic [2:0] railEnable,
   output logic line_zero_cross_in,
   output logic [7:0] low_raw_rail,
   output logic [7:0] high_raw_rail
);
   int phase;
   logic fired;
   // Square line; a dead line parks low so no crossing shows
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n || !lineOn) begin
         phase <= 0;
         line_zero_cross_in <= 1'b0;
      end else begin
         phase <= (phase == 2 * HALF - 1) ? 0 : phase + 1;
         line_zero_cross_in <= (phase < HALF);
      end
   end
   // Firing charges just above target, far below it under sag; an unfired cycle drains a step
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         low_raw_rail <= 8'h00;
         high_raw_rail <= 8'h00;
         fired <= 1'b0;
      end else if (railEnable[0] || railEnable[1]) begin
         low_raw_rail <= sag ? 8'h40 : 8'hb4;
         high_raw_rail <= sag ? 8'h50 : 8'hc4;
         fired <= 1'b1;
      end else if (phase == 0) begin
         fired <= 1'b0;
         if (!fired) begin
            low_raw_rail <= (low_raw_rail > 8'h10) ? low_raw_rail - 8'h10 : 8'h00;
            high_raw_rail <= (high_raw_rail > 8'h10) ? high_raw_rail - 8'h10 : 8'h00;
         end
      end
   end
endmodule

// ===== bench/seq_checker.sv
// Checker: port timing properties of the supply sequencer
`timescale 1ns/1ps
module seq_checker #(
   parameter int FAIL_LIMIT = 200,
   parameter int SPLIT_LIMIT = 66
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic line_zero_cross_in,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [2:0] railEnable,
   input wire logic sysReset,
   input wire logic tickIrq,
   input wire logic powerFailIrq
);
   logic [15:0] gap_q;
   logic line_q;
   // Cycles since the line rose; saturates so a dead line never wraps
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gap_q <= 16'h0000;
         line_q <= 1'b0;
      end else begin
         line_q <= line_zero_cross_in;
         if (line_zero_cross_in && !line_q) begin
            gap_q <= 16'h0000;
         end else if (gap_q != 16'hffff) begin
            gap_q <= gap_q + 16'h0001;
         end
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   sequence s_held;
      $past(sysReset) && sysReset && !$past(powerFailIrq);
   endsequence
   sequence s_offHeld;
      (sysReset && railEnable == 3'h0) [*8];
   endsequence
   property p_busOkay;
      hreadyout && !hresp;
   endproperty
   property p_rampOne;
      s_held |-> $countones(railEnable ^ $past(railEnable)) <= 1;
   endproperty
   property p_failOn;
      powerFailIrq && $past(powerFailIrq) |-> railEnable == 3'h7;
   endproperty
   property p_drainOff;
      $fell(powerFailIrq) |-> ##[0:1] s_offHeld;
   endproperty
   property p_tickPulse;
      tickIrq |=> !tickIrq [*8];
   endproperty
   property p_tickCause;
      tickIrq |-> gap_q inside {[16'h0001:16'h0006]};
   endproperty
   property p_failDetect;
      !sysReset && gap_q > FAIL_LIMIT + 8 |-> powerFailIrq;
   endproperty
   property p_release;
      $fell(sysReset) |-> $past(railEnable) == 3'h7 && !powerFailIrq;
   endproperty
   a_busOkay: assert property (p_busOkay) else $error("bus answer not okay");
   a_rampOne: assert property (p_rampOne) else $error("rails switched together");
   a_failOn: assert property (p_failOn) else $error("rails not full on");
   a_drainOff: assert property (p_drainOff) else $error("rails not held off");
   a_tickPulse: assert property (p_tickPulse) else $error("tick too long");
   a_tickCause: assert property (p_tickCause) else $error("tick without crossing");
   a_failDetect: assert property (p_failDetect) else $error("dead line missed");
   a_release: assert property (p_release) else $error("early reset release");
endmodule
bind supply_sequencer seq_checker #(.FAIL_LIMIT(FAIL_LIMIT), .SPLIT_LIMIT(SPLIT_LIMIT)) chk (
   .clk(clk), .arst_n(arst_n), .line_zero_cross_in(line_zero_cross_in), .hresp(hresp),
   .hreadyout(hreadyout), .railEnable(railEnable), .sysReset(sysReset), .tickIrq(tickIrq),
   .powerFailIrq(powerFailIrq));

// ===== bench/testbench.sv
// Testbench: bus, power-up, shutdown and fault scenarios
`timescale 1ns/1ps
module testbench
   import seq_pkg::*;
;
   logic clk, arst_n, hsel, hwrite, hreadyout, hresp, rdPend, tickArm, lineOn, sag;
   logic line_zero_cross_in, sixtyHzStrap, offSwitch, sysReset, coldStart, tickIrq, powerFailIrq;
   logic [1:0] htrans;
   logic [2:0] hsize, railEnable;
   logic [7:0] low_raw_rail, high_raw_rail;
   logic [31:0] haddr, hwdata, hrdata, rnd, expQ[$];
   int mismatches, nTests, crossCnt, sinceTick, expDiv;
   supply_sequencer #(.FAIL_LIMIT(200), .SPLIT_LIMIT(66)) dut (
      .clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .line_zero_cross_in(line_zero_cross_in),
      .sixtyHzStrap(sixtyHzStrap), .offSwitch(offSwitch), .low_raw_rail(low_raw_rail),
      .high_raw_rail(high_raw_rail), .railEnable(railEnable), .sysReset(sysReset),
      .coldStart(coldStart), .tickIrq(tickIrq), .powerFailIrq(powerFailIrq));
   rail_partner #(.HALF(30)) mains (.clk(clk), .arst_n(arst_n), .lineOn(lineOn), .sag(sag),
      .railEnable(railEnable), .line_zero_cross_in(line_zero_cross_in),
      .low_raw_rail(low_raw_rail), .high_raw_rail(high_raw_rail));
   always #50 clk = ~clk;
   task automatic testDone();
      if (mismatches == 0 && nTests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      nTests++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask
   // Single word transfer; a read leaves its expected word in the queue
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h000000, a};
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= w ? d : 32'h0;
      rdPend <= !w;
      if (!w) expQ.push_back(d);
      do @(posedge clk); while (hreadyout !== 1'b1);
      rdPend <= 1'b0;
   endtask
   task automatic waitX(input int n);
      repeat (n) @(posedge line_zero_cross_in);
      repeat (8) @(posedge clk);
   endtask
   task automatic powerUp(input logic cold, input int div);
      crossCnt = 0;
      expDiv = 0;
      lineOn <= 1'b1;
      for (int i = 0; i < 20000 && railEnable !== 3'h1 && railEnable !== 3'h2; i++) begin
         @(negedge clk);
      end
      expDiv = div;
      tickArm = 1'b0;
      chk(crossCnt >= 50, "rails before mains settled");
      chk(sysReset === 1'b1 && coldStart === cold, "reset or start mark");
      for (int n = 1; n <= 3; n++) begin
         chk($countones(railEnable) == n, "rail step");
         if (n < 3) waitX(1);
      end
      for (int i = 0; i < 8000 && sysReset === 1'b1; i++) @(negedge clk);
      chk(sysReset === 1'b0, "reset not released");
      @(posedge clk);
   endtask
   // Failure, hold-up, then switches off under reset
   task automatic down();
      for (int i = 0; i < 30000 && powerFailIrq !== 1'b1; i++) @(negedge clk);
      @(negedge clk);
      chk(powerFailIrq === 1'b1 && railEnable === 3'h7, "fail or rails");
      for (int i = 0; i < 5000 && sysReset !== 1'b1; i++) @(negedge clk);
      @(negedge clk);
      chk(sysReset === 1'b1 && railEnable === 3'h0, "shutdown end");
      @(posedge clk);
   endtask
   // Read data against the oldest note; tick spacing in crossings
   always @(posedge clk) begin
      if (rdPend === 1'b1 && hreadyout === 1'b1) chk(hrdata === expQ.pop_front(), "read");
      if (tickIrq === 1'b1) begin
         if (tickArm && expDiv != 0) chk(sinceTick == expDiv, "tick spacing");
         tickArm = 1'b1;
         sinceTick = 0;
      end
   end
   always @(posedge line_zero_cross_in) begin
      sinceTick++;
      crossCnt++;
   end
   initial begin
      repeat (90000) @(posedge clk);
      mismatches++;
      testDone();
   end
   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      {hsel, hwrite, rdPend, lineOn, sag, offSwitch, sixtyHzStrap, tickArm} = 8'h00;
      htrans = 2'b00;
      hsize = 3'b010;
      haddr = 32'h0;
      hwdata = 32'h0;
      expDiv = DIV50;
      rnd = $urandom(32'hbf11);
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      bus(1'b0, CTRL_OFF, CTRL_RESET);
      bus(1'b0, RESET_DELAY_OFF, RESET_DELAY_RESET);
      bus(1'b0, HOLDUP_OFF, HOLDUP_RESET);
      bus(1'b0, LEVELS_OFF, LEVELS_RESET);
      bus(1'b0, 8'h1c, 32'h0);
      rnd = 32'h2 + ($urandom % 32'h3);
      bus(1'b1, RESET_DELAY_OFF, rnd);
      bus(1'b0, RESET_DELAY_OFF, rnd);
      bus(1'b1, RAILS_OFF, 32'hffff_ffff);
      bus(1'b0, RAILS_OFF, 32'h0);
      // Brief mains return must not start anything
      lineOn <= 1'b1;
      waitX(20);
      lineOn <= 1'b0;
      repeat (400) @(posedge clk);
      chk(railEnable === 3'h0 && sysReset === 1'b1, "short mains");
      powerUp(1'b1, 5);
      waitX(20);
      offSwitch <= 1'b1;
      down();
      waitX(60);
      chk(railEnable === 3'h0 && coldStart === 1'b0, "held off or warm");
      sixtyHzStrap <= 1'b1;
      offSwitch <= 1'b0;
      powerUp(1'b0, 6);
      waitX(20);
      sag <= 1'b1;
      down();
      sag <= 1'b0;
      sixtyHzStrap <= 1'b0;
      bus(1'b1, CTRL_OFF, CTRL_RESET | (32'h1 << CTRL_AUTOFREQ_BIT));
      powerUp(1'b1, 6);
      lineOn <= 1'b0;
      down();
      testDone();
   end
endmodule

// ===== hw/phase_regulator.sv
// Phase-angle regulator for one raw rail
`timescale 1ns/1ps
module phase_regulator
   import seq_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [31:0] halfPeriod,
   phase_if.reg_side pif
);
   typedef struct packed {
      logic [PHASE_W-1:0] angle;
      logic [31:0] sinceCross;
      logic fire;
      logic brown;
   } reg_state_t;
   reg_state_t s_q, s_d;

   // Angle moves one step per crossing; firing delay shrinks as angle grows
   always_comb begin
      logic [39:0] delay;
      s_d = s_q;
      delay = 40'(halfPeriod) * 40'(PHASE_MAX - s_q.angle);
      if (pif.crossing) begin
         s_d.sinceCross = '0;
         s_d.fire = 1'b0;
         if (pif.rawLevel < pif.target && s_q.angle != PHASE_MAX) begin
            s_d.angle = s_q.angle + 8'h01;
         end else if (pif.rawLevel > pif.target && s_q.angle != 8'h00) begin
            s_d.angle = s_q.angle - 8'h01;
         end
         // Too much on-time needed means the line is sagging
         s_d.brown = s_q.angle >= pif.brownLimit;
      end else begin
         s_d.sinceCross = s_q.sinceCross + 32'h1;
         if (s_q.sinceCross >= delay[39:8]) begin
            s_d.fire = 1'b1;
         end
      end
      if (!pif.enable) begin
         s_d.fire = 1'b0;
         s_d.brown = 1'b0;
         s_d.angle = PHASE_START;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '{angle: PHASE_START, sinceCross: 32'h0, fire: 1'b0, brown: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign pif.fire = s_q.fire;
   assign pif.brownOut = s_q.brown;
endmodule

// ===== hw/supply_sequencer.sv
// Line-powered three-rail supply sequencer with AHB-Lite register slave
// What this block does
// - Tick by dividing crossings by five or six
// - Strap picks 50 or 60 Hz divisor
// - Rails stay off until mains is stable
// - Assert reset and cold start before rails
// - After crossing, enable rails one at a time
// - Release reset after programmable delay
// - Regulate raw rails by phase angle
// - Missing crossing past limit raises power-fail once reset is released
// - Excess on-time raises power-fail as brown-out
// - Power-fail drives all switches fully on
// - Hold-up delay then assert reset
// - Switches off until rails drain low
// - Off switch runs shutdown, warm start
// - Optionally measure line period at startup
//
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module supply_sequencer
   import seq_pkg::*;
#(
   parameter int FAIL_LIMIT = FAIL_CYCLES,
   parameter int SPLIT_LIMIT = SPLIT_CYCLES
) (
   input wire logic clk,
   input wire logic arst_n,
   // Register bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Line and rail measurements
   input wire logic line_zero_cross_in,
   input wire logic sixtyHzStrap,
   input wire logic offSwitch,
   input wire logic [7:0] low_raw_rail,
   input wire logic [7:0] high_raw_rail,
   // Rail switches and host signals
   output logic [2:0] railEnable,
   output logic sysReset,
   output logic coldStart,
   output logic tickIrq,
   output logic powerFailIrq
);
   typedef struct packed {
      // Crossing synchroniser, sequencer state and interval timing
      logic [1:0] zcSync;
      logic zcPrev;
      seq_state_t state;
      logic [31:0] lineTimer;
      logic [31:0] period;
      // Sequencer progress and outputs
      logic [7:0] stableCnt;
      logic [7:0] delayCnt;
      logic [1:0] railStep;
      logic [2:0] rails;
      logic sysReset;
      logic cold;
      logic fail;
      logic sixty;
      // Tick divider
      logic [2:0] tickCnt;
      logic tick;
      logic [15:0] ticks;
      // Software registers
      logic [31:0] ctrl;
      logic [31:0] resetDelay;
      logic [31:0] holdup;
      logic [31:0] levels;
      // Bus data phase memory
      logic dataPhase;
      logic dataWrite;
      logic [7:0] dataAddr;
      logic [31:0] rdata;
   } state_t;
   state_t s_q, s_d;

   phase_if lowIf();
   phase_if highIf();
   logic zcEvent;
   logic [1:0] orderSel;
   logic [1:0] railIdx;

   // Crossing event from the second synchroniser stage only
   assign zcEvent = s_q.zcSync[1] & ~s_q.zcPrev;

   // Rail order: rotation of 0,1,2 chosen by software
   assign orderSel = s_q.ctrl[CTRL_ORDER_LSB +: 2];
   always_comb begin
      logic [2:0] sum;
      sum = {1'b0, s_q.railStep} + {1'b0, orderSel};
      railIdx = (sum >= 3'd3) ? 2'(sum - 3'd3) : sum[1:0];
   end

   // Regulator hookups
   // Both regulators share the crossing event and the measured period
   assign lowIf.crossing = zcEvent;
   assign lowIf.rawLevel = low_raw_rail;
   assign lowIf.target = s_q.levels[7:0];
   assign lowIf.brownLimit = s_q.ctrl[CTRL_BROWN_LSB +: 8];
   assign lowIf.enable = s_q.state == ST_RUN;
   assign highIf.crossing = zcEvent;
   assign highIf.rawLevel = high_raw_rail;
   assign highIf.target = s_q.levels[15:8];
   assign highIf.brownLimit = s_q.ctrl[CTRL_BROWN_LSB +: 8];
   assign highIf.enable = s_q.state == ST_RUN;

   phase_regulator lowReg (
      .clk(clk),
      .arst_n(arst_n),
      .halfPeriod(s_q.period),
      .pif(lowIf.reg_side)
   );
   phase_regulator highReg (
      .clk(clk),
      .arst_n(arst_n),
      .halfPeriod(s_q.period),
      .pif(highIf.reg_side)
   );

   // Next state of the whole block; the two regulators run alongside
   // and only report firing and brown-out back
   always_comb begin
      logic crossTimeout;
      logic brown;
      logic [7:0] drainLevel;
      s_d = s_q;
      crossTimeout = s_q.lineTimer >= 32'(FAIL_LIMIT);
      brown = lowIf.brownOut | highIf.brownOut;
      drainLevel = s_q.levels[31:24];
      s_d.tick = 1'b0;

      // Input sampling and edge memory
      s_d.zcSync = {s_q.zcSync[0], line_zero_cross_in};
      s_d.zcPrev = s_q.zcSync[1];

      // Interval between crossings
      // Timer stops at the limit so a dead line never wraps round
      if (zcEvent) begin
         s_d.lineTimer = '0;
         s_d.period = s_q.lineTimer;
      end else if (!crossTimeout) begin
         s_d.lineTimer = s_q.lineTimer + 32'h1;
      end

      // Tick divider, not restarted when the frequency choice changes
      // A count left above a smaller divisor wraps at the next crossing
      if (zcEvent) begin
         if (s_q.tickCnt >= 3'(s_q.sixty ? DIV60 - 1 : DIV50 - 1)) begin
            s_d.tickCnt = '0;
            s_d.tick = 1'b1;
            s_d.ticks = s_q.ticks + 16'h1;
         end else begin
            s_d.tickCnt = s_q.tickCnt + 3'h1;
         end
      end

      // Sequencer
      case (s_q.state)
         ST_WAIT_MAINS: begin
            // Rails off and reset held until enough clean crossings
            s_d.rails = 3'b000;
            s_d.sysReset = 1'b1;
            s_d.fail = 1'b0;
            if (crossTimeout) begin
               s_d.stableCnt = '0;
               // A mains gap makes the next start a cold one
               s_d.cold = 1'b1;
            end else if (zcEvent) begin
               if (s_q.stableCnt == 8'(STABLE_CROSSINGS - 1)) begin
                  s_d.state = ST_ARM;
                  // Start type stands as the last shutdown or mains gap left it
                  s_d.stableCnt = '0;
                  // Long period means 50 Hz when measuring is chosen
                  if (s_q.ctrl[CTRL_AUTOFREQ_BIT]) begin
                     s_d.sixty = s_q.lineTimer < 32'(SPLIT_LIMIT);
                  end else begin
                     s_d.sixty = sixtyHzStrap;
                  end
               end else begin
                  s_d.stableCnt = s_q.stableCnt + 8'h1;
               end
            end
         end
         ST_ARM: begin
            // Reset stays up while waiting for a crossing
            s_d.sysReset = 1'b1;
            if (zcEvent) begin
               s_d.state = ST_RAMP;
               s_d.railStep = '0;
            end
         end
         ST_RAMP: begin
            // One rail per crossing limits inrush
            // The order rotation picks which rail comes first
            if (zcEvent) begin
               s_d.rails[railIdx] = 1'b1;
               if (s_q.railStep == 2'd2) begin
                  s_d.state = ST_HOLD_RESET;
                  s_d.delayCnt = '0;
               end else begin
                  s_d.railStep = s_q.railStep + 2'd1;
               end
            end
         end
         ST_HOLD_RESET: begin
            // Delay counted in ticks once all rails are on
            if (s_q.tick) begin
               s_d.delayCnt = s_q.delayCnt + 8'h1;
            end
            if (s_q.delayCnt >= s_q.resetDelay[7:0]) begin
               s_d.sysReset = 1'b0;
               s_d.state = ST_RUN;
            end
         end
         ST_RUN: begin
            // Rail 2 is full on; the other two follow their regulators
            s_d.rails = {1'b1, highIf.fire, lowIf.fire};
            if (crossTimeout || brown || offSwitch) begin
               s_d.fail = 1'b1;
               s_d.cold = !offSwitch;
               s_d.state = ST_HOLDUP;
               s_d.delayCnt = '0;
            end
         end
         ST_HOLDUP: begin
            s_d.rails = 3'b111;
            // Ticks may stop with the line, so the timeout also counts
            if (s_q.tick || crossTimeout) begin
               s_d.delayCnt = s_q.delayCnt + 8'h1;
            end
            // Restart the timer so a dead line adds one step per limit span,
            // not one per clock
            if (crossTimeout) begin
               s_d.lineTimer = '0;
            end
            if (s_q.delayCnt >= s_q.holdup[7:0]) begin
               s_d.sysReset = 1'b1;
               s_d.state = ST_DRAIN;
            end
         end
         ST_DRAIN: begin
            // Switches off until both rails sag below the drain level
            s_d.rails = 3'b000;
            s_d.fail = 1'b0;
            if (low_raw_rail < drainLevel && high_raw_rail < drainLevel && !offSwitch) begin
               s_d.state = ST_WAIT_MAINS;
               s_d.stableCnt = '0;
            end
         end
         default: begin
            // Unused codes fall back to the safe start
            s_d.state = ST_WAIT_MAINS;
         end
      endcase

      // Bus data phase: writes land one cycle after the address phase
      if (s_q.dataPhase && s_q.dataWrite) begin
         if (s_q.dataAddr == CTRL_OFF) begin
            s_d.ctrl = hwdata;
         end else if (s_q.dataAddr == RESET_DELAY_OFF) begin
            s_d.resetDelay = hwdata;
         end else if (s_q.dataAddr == HOLDUP_OFF) begin
            s_d.holdup = hwdata;
         end else if (s_q.dataAddr == LEVELS_OFF) begin
            s_d.levels = hwdata;
         end
      end
      // Address phase capture and read data preparation
      // Read data is registered here so it stands through the data phase
      s_d.dataPhase = hsel && hready && htrans[1];
      s_d.dataWrite = hwrite;
      s_d.dataAddr = haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite) begin
         if (haddr[7:0] == CTRL_OFF) begin
            s_d.rdata = s_q.ctrl;
         end else if (haddr[7:0] == RESET_DELAY_OFF) begin
            s_d.rdata = s_q.resetDelay;
         end else if (haddr[7:0] == HOLDUP_OFF) begin
            s_d.rdata = s_q.holdup;
         end else if (haddr[7:0] == LEVELS_OFF) begin
            s_d.rdata = s_q.levels;
         end else if (haddr[7:0] == STATUS_OFF) begin
            s_d.rdata = {24'h0, s_q.sixty, s_q.fail, s_q.cold, s_q.sysReset,
                         1'b0, s_q.state};
         end else if (haddr[7:0] == RAILS_OFF) begin
            s_d.rdata = {21'h0, s_q.rails, 8'h00};
         end else if (haddr[7:0] == TICKS_OFF) begin
            s_d.rdata = {16'h0, s_q.ticks};
         end else begin
            s_d.rdata = 32'h0; // Unmapped reads as zero
         end
      end
   end

   // Single state register; reset parks the block with rails off and reset up
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '{
            zcSync: 2'b00,
            zcPrev: 1'b0,
            state: ST_WAIT_MAINS,
            lineTimer: 32'h0,
            period: 32'h0,
            stableCnt: 8'h00,
            delayCnt: 8'h00,
            railStep: 2'b00,
            rails: 3'b000,
            sysReset: 1'b1,
            cold: 1'b1,
            fail: 1'b0,
            sixty: 1'b0,
            tickCnt: 3'h0,
            tick: 1'b0,
            ticks: 16'h0000,
            ctrl: CTRL_RESET,
            resetDelay: RESET_DELAY_RESET,
            holdup: HOLDUP_RESET,
            levels: LEVELS_RESET,
            dataPhase: 1'b0,
            dataWrite: 1'b0,
            dataAddr: 8'h00,
            rdata: 32'h0
         };
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs
   assign hrdata = s_q.rdata;
   assign hreadyout = 1'b1; // Zero wait states
   assign hresp = 1'b0;
   assign railEnable = s_q.rails;
   assign sysReset = s_q.sysReset;
   assign coldStart = s_q.cold;
   assign tickIrq = s_q.tick;
   assign powerFailIrq = s_q.fail;
endmodule

// ===== include/phase_if.sv
// Interface: per-crossing phase regulation request and result
`timescale 1ns/1ps
interface phase_if;
   logic crossing;
   logic [7:0] rawLevel;
   logic [7:0] target;
   logic [7:0] brownLimit;
   logic enable;
   logic fire;
   logic brownOut;
   modport ctrl (output crossing, rawLevel, target, brownLimit, enable, input fire, brownOut);
   modport reg_side (input crossing, rawLevel, target, brownLimit, enable, output fire, brownOut);
endinterface

// ===== include/seq_pkg.sv
// Package: register map, timing constants and state encodings of the supply sequencer
package seq_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] RESET_DELAY_OFF = 8'h04;
   localparam logic [7:0] HOLDUP_OFF = 8'h08;
   localparam logic [7:0] LEVELS_OFF = 8'h0c;
   localparam logic [7:0] STATUS_OFF = 8'h10;
   localparam logic [7:0] RAILS_OFF = 8'h14;
   localparam logic [7:0] TICKS_OFF = 8'h18;
   // Control fields
   localparam int CTRL_ORDER_LSB = 0;
   localparam int CTRL_AUTOFREQ_BIT = 6;
   localparam int CTRL_BROWN_LSB = 8;
   // Reset values
   localparam logic [31:0] CTRL_RESET = 32'h0000_e024;
   localparam logic [31:0] RESET_DELAY_RESET = 32'h0000_0005;
   localparam logic [31:0] HOLDUP_RESET = 32'h0000_0003;
   localparam logic [31:0] LEVELS_RESET = 32'h2010_c0b0;
   // Line timing, 10 MHz clock
   localparam int CLK_HZ = 10_000_000;
   localparam int FAIL_MS = 30;
   localparam int FAIL_CYCLES = CLK_HZ / 1000 * FAIL_MS;
   localparam int STABLE_CROSSINGS = 50;
   localparam int SPLIT_US = 18_333;
   localparam int SPLIT_CYCLES = CLK_HZ / 1_000_000 * SPLIT_US;
   localparam int DIV50 = 5;
   localparam int DIV60 = 6;
   localparam int PHASE_W = 8;
   localparam logic [PHASE_W-1:0] PHASE_MAX = 8'hff;
   localparam logic [PHASE_W-1:0] PHASE_START = 8'h80;

   typedef enum logic [2:0] {
      ST_WAIT_MAINS = 3'b000,
      ST_ARM = 3'b001,
      ST_RAMP = 3'b010,
      ST_HOLD_RESET = 3'b011,
      ST_RUN = 3'b100,
      ST_HOLDUP = 3'b101,
      ST_DRAIN = 3'b110
   } seq_state_t;
endpackage
